// ==== core/dli_cs_space.sv ====
// Control/status byte space of the debug link.
// Assumes one clock; reads are combinational on the engine's address.
`include "dli_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module dli_cs_space (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Byte access from the engine
    input wire logic we,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdData,
    // Error signature capture
    input wire logic errSet,
    input wire logic [2:0] errCode,
    // Guard setting
    output logic [2:0] guardCode
);

    // ==================================================================
    // Register array
    logic [7:0] regs [16];
    logic [7:0] next_regs [16];

    // A whole byte is written; an error signature wins over a clear.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            next_regs[i] = regs[i];
        end
        if (we) begin
            next_regs[addr] = wdata; // RL11
        end
        if (errSet) begin
            next_regs[`DLI_CS_STATUS] = {5'h00, errCode};
        end
    end

    // Registers only.
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 16; i++) begin
            if (!reset_n) begin
                regs[i] <= `DLI_CS_RESET;
            end else begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // Single byte read from the link's own space only.
    assign rdData = regs[addr]; // RL8
    assign guardCode = regs[`DLI_CS_CTRL][2:0];

endmodule : dli_cs_space

`default_nettype wire

// ==== core/dli_link_engine.sv ====
// Instruction engine of the one-wire debug link, above the bit-serial layer.
// Assumes byte strobes, break, error and bit-time ticks come from the
// bit-serial layer on core_clk, and a data-space bus slave on core_clk.
`include "dli_regs.svh"
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RL1: Pointer load reads bus, shifts result out.
// RL2: Pointer load waits guard idle bits first.
// RL3: Host loads pointer with mode two, waits.
// RL4: Mode zero keeps pointer; mode one advances.
// RL5: Acknowledge after every pointer store.
// RL6: Host sends exact data bytes, awaits acknowledge.
// RL7: Pointer load can return pointer register.
// RL8: Control read: operand address, one byte.
// RL9: Control read byte follows guard interval.
// RL10: Control write takes byte, gives no answer.
// RL11: Control write reaches only own registers.
// RL12: Repeat stores operand count, up to 255.
// RL13: Next instruction runs count plus one.
// RL14: Repeats carry only operand or data frames.
// RL15: Repeat itself is never repeated.
// RL16: Only break aborts a running repeat.
// RL17: Repeated store: data, then acknowledge, each.
// RL18: Repeated load streams; guard only first.
// RL19: Host resends address for direct repeats.
// RL20: Repeat size field sizes count operand.
// RL21: Keys are 64 bits; info up to 128.
// RL22: No answer to keys; info after guard.
// RL23: Address size codes one, two, three bytes.
// RL24: Error state ignores all until break.
module dli_link_engine (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bytes from the bit-serial layer
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxBreak,
    input wire logic rxError,
    input wire logic bitTick,
    // Bytes to the bit-serial layer
    input wire logic txReady,
    output logic txValid,
    output logic [7:0] txData,
    // Data-space bus
    output logic busReq,
    output dli_pkg::dli_bus_cmd_t busCmd,
    input wire logic busAck,
    input wire logic busErr,
    input wire logic [15:0] busRdata,
    // Key and info block
    output logic keyStrobe,
    output logic [63:0] keyData,
    input wire logic [127:0] infoBlock
);

    // ==================================================================
    // Helpers
    function automatic logic [4:0] bytesA(input logic [1:0] c);
        return (c == 2'h0) ? 5'h01 : ((c == 2'h1) ? 5'h02 : 5'h03); // RL23
    endfunction : bytesA

    function automatic logic [4:0] bytesB(input logic [1:0] c);
        return c[0] ? 5'h02 : 5'h01;
    endfunction : bytesB

    // Bytes arrive low first and enter at the top of the collector.
    function automatic logic [63:0] alignLe(input logic [63:0] a, input logic [4:0] n);
        return a >> (8'h40 - {n, 3'h0});
    endfunction : alignLe

    // Reserved size or mode codes are treated as errors.
    function automatic logic badCode(input logic [7:0] i);
        logic [1:0] m;
        m = i[`DLI_MODE_MSB:`DLI_MODE_LSB];
        case (i[`DLI_OPC_MSB:`DLI_OPC_LSB])
            `DLI_OP_LOAD_DIRECT, `DLI_OP_WRITE_DIRECT, `DLI_OP_LOAD_PTR: return (m == `DLI_SIZE_RSVD) || i[1];
            `DLI_OP_WRITE_PTR: return (m == `DLI_SIZE_RSVD) || ((m == `DLI_PTR_REG) ? (i[1:0] == `DLI_SIZE_RSVD) : i[1]);
            `DLI_OP_REPEAT: return i[1];
            `DLI_OP_KEY: return i[1] || (!i[`DLI_INFO_BIT] && i[0]); // RL21
            default: return 1'b0;
        endcase
    endfunction : badCode

    // ==================================================================
    // State
    dli_pkg::dli_state_t state, next_state;
    dli_pkg::dli_bus_cmd_t next_busCmd;
    logic [7:0] instr, next_instr, rpt, next_rpt, guardCnt, next_guardCnt;
    logic [31:0] ptr, next_ptr;
    logic [63:0] acc, next_acc, next_keyData;
    logic [4:0] cnt, next_cnt, need, next_need, sendLeft, next_sendLeft;
    logic [127:0] sendBuf, next_sendBuf;
    logic guardDue, next_guardDue, dataPhase, next_dataPhase;
    logic next_txValid, next_busReq, next_keyStrobe;
    logic [7:0] next_txData;
    logic launch, finish, csWe, errSet;
    logic [7:0] li, csWdata, csRdData, guardLimit;
    logic [3:0] csAddr;
    logic [2:0] errCode, guardCode, opc;
    logic [1:0] pm;
    logic [63:0] val;

    assign opc = instr[`DLI_OPC_MSB:`DLI_OPC_LSB];
    assign pm = instr[`DLI_MODE_MSB:`DLI_MODE_LSB];
    assign guardLimit = {5'h00, guardCode} + `DLI_GUARD_BASE;

    dli_cs_space u_cs (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .we(csWe),
        .addr(csAddr),
        .wdata(csWdata),
        .rdData(csRdData),
        .errSet(errSet),
        .errCode(errCode),
        .guardCode(guardCode)
    );

    // ==================================================================
    // Sequencer: operand and data collection, bus access, replies.
    always_comb begin
        next_state = state; next_instr = instr; next_rpt = rpt; next_ptr = ptr;
        next_acc = acc; next_cnt = cnt; next_need = need; next_sendBuf = sendBuf;
        next_sendLeft = sendLeft; next_guardDue = guardDue; next_guardCnt = guardCnt;
        next_dataPhase = dataPhase; next_txValid = txValid; next_txData = txData;
        next_busReq = busReq; next_busCmd = busCmd; next_keyStrobe = 1'b0;
        next_keyData = keyData; launch = 1'b0; finish = 1'b0; li = instr;
        csWe = 1'b0; csAddr = instr[3:0]; csWdata = rxData; errSet = 1'b0;
        errCode = `DLI_ERR_LINK; val = 64'h0;
        case (state)
            dli_pkg::S_IDLE: begin
                if (rxValid) begin
                    next_instr = rxData;
                    li = rxData;
                    launch = 1'b1;
                end
            end
            dli_pkg::S_OPND: begin
                if (rxValid) begin
                    next_acc = {rxData, acc[63:8]};
                    next_cnt = cnt + 5'h01;
                    if (next_cnt == need) begin
                        val = alignLe(next_acc, need);
                        next_sendBuf = {120'h0, `DLI_ACK_BYTE};
                        next_sendLeft = 5'h01;
                        case (opc)
                            `DLI_OP_LOAD_DIRECT: begin
                                next_busCmd = '{we: 1'b0, wide: instr[0], addr: val[31:0], wdata: 16'h0};
                                next_busReq = 1'b1;
                                next_state = dli_pkg::S_BUS;
                            end
                            `DLI_OP_WRITE_DIRECT: begin
                                next_busCmd.addr = val[31:0];
                                next_state = dli_pkg::S_GUARD;
                            end
                            `DLI_OP_WRITE_PTR: begin
                                next_ptr = val[31:0];
                                next_state = dli_pkg::S_GUARD; // RL5
                            end
                            default: begin
                                next_rpt = val[7:0]; // RL12
                                next_state = dli_pkg::S_IDLE; // RL15
                            end
                        endcase
                    end
                end
            end
            dli_pkg::S_DATA: begin
                if (rxValid) begin
                    next_acc = {rxData, acc[63:8]};
                    next_cnt = cnt + 5'h01;
                    if (next_cnt == need) begin
                        val = alignLe(next_acc, need);
                        case (opc)
                            `DLI_OP_WRITE_CS: begin
                                csWe = 1'b1; // RL10
                                finish = 1'b1;
                            end
                            `DLI_OP_KEY: begin
                                next_keyData = val; // RL21
                                next_keyStrobe = 1'b1; // RL22
                                finish = 1'b1;
                            end
                            default: begin
                                next_busCmd.we = 1'b1;
                                next_busCmd.wide = instr[0];
                                next_busCmd.wdata = val[15:0];
                                if (opc == `DLI_OP_WRITE_PTR) begin
                                    next_busCmd.addr = ptr;
                                end
                                next_busReq = 1'b1;
                                next_state = dli_pkg::S_BUS;
                            end
                        endcase
                    end
                end
            end
            dli_pkg::S_BUS: begin
                if (busAck) begin
                    next_busReq = 1'b0;
                    next_sendBuf = busCmd.we ? {120'h0, `DLI_ACK_BYTE} : {112'h0, busRdata}; // RL1 RL5
                    next_sendLeft = busCmd.we ? 5'h01 : bytesB(instr[1:0]);
                    next_state = dli_pkg::S_GUARD;
                    if (opc[0] && pm == `DLI_PTR_INC) begin
                        next_ptr = ptr + 32'(bytesB(instr[1:0])); // RL4
                    end
                    if (busErr) begin
                        errSet = 1'b1;
                        errCode = `DLI_ERR_BUS;
                        next_state = dli_pkg::S_ERR; // RL24
                    end
                end
            end
            dli_pkg::S_GUARD: begin
                // A direction change costs guard bits; a continuing stream does not.
                if (!guardDue || guardCnt >= guardLimit) begin
                    next_txValid = 1'b1; // RL2 RL9 RL18
                    next_txData = sendBuf[7:0];
                    next_guardDue = 1'b0;
                    next_guardCnt = 8'h00;
                    next_state = dli_pkg::S_SEND;
                end else if (bitTick) begin
                    next_guardCnt = guardCnt + 8'h01;
                end
            end
            dli_pkg::S_SEND: begin
                if (txReady) begin
                    next_sendBuf = sendBuf >> 8;
                    next_sendLeft = sendLeft - 5'h01;
                    next_txData = sendBuf[15:8];
                    if (sendLeft == 5'h01) begin
                        next_txValid = 1'b0;
                        if (opc == `DLI_OP_WRITE_DIRECT && !dataPhase) begin
                            next_dataPhase = 1'b1;
                            next_cnt = 5'h00;
                            next_need = bytesB(instr[1:0]);
                            next_state = dli_pkg::S_DATA;
                        end else begin
                            finish = 1'b1;
                        end
                    end
                end
            end
            dli_pkg::S_ERR: begin
                next_state = dli_pkg::S_ERR; // RL24
            end
            default: begin
                next_state = dli_pkg::S_IDLE;
            end
        endcase
        // Further iterations skip the instruction frame and relaunch the held instruction byte.
        if (finish) begin
            next_state = dli_pkg::S_IDLE;
            if (rpt != 8'h00) begin
                next_rpt = rpt - 8'h01; // RL13
                launch = 1'b1; // RL14 RL17
            end
        end
        if (launch) begin
            next_cnt = 5'h00;
            next_dataPhase = 1'b1;
            csAddr = li[3:0];
            if (badCode(li)) begin
                errSet = 1'b1;
                errCode = `DLI_ERR_CODE;
                next_state = dli_pkg::S_ERR; // RL24
            end else begin
                case (li[`DLI_OPC_MSB:`DLI_OPC_LSB])
                    `DLI_OP_LOAD_DIRECT, `DLI_OP_WRITE_DIRECT: begin
                        next_need = bytesA(li[`DLI_MODE_MSB:`DLI_MODE_LSB]); // RL23
                        next_dataPhase = 1'b0;
                        next_state = dli_pkg::S_OPND;
                    end
                    `DLI_OP_LOAD_PTR: begin
                        if (li[`DLI_MODE_MSB:`DLI_MODE_LSB] == `DLI_PTR_REG) begin
                            next_sendBuf = {96'h0, ptr}; // RL7
                            next_sendLeft = bytesB(li[1:0]);
                            next_state = dli_pkg::S_GUARD;
                        end else begin
                            next_busCmd = '{we: 1'b0, wide: li[0], addr: ptr, wdata: 16'h0}; // RL1
                            next_busReq = 1'b1;
                            next_state = dli_pkg::S_BUS;
                        end
                    end
                    `DLI_OP_WRITE_PTR: begin
                        if (li[`DLI_MODE_MSB:`DLI_MODE_LSB] == `DLI_PTR_REG) begin
                            next_need = bytesA(li[1:0]);
                            next_state = dli_pkg::S_OPND;
                        end else begin
                            next_need = bytesB(li[1:0]);
                            next_state = dli_pkg::S_DATA;
                        end
                    end
                    `DLI_OP_READ_CS: begin
                        next_sendBuf = {120'h0, csRdData}; // RL8
                        next_sendLeft = 5'h01;
                        next_state = dli_pkg::S_GUARD; // RL9
                    end
                    `DLI_OP_WRITE_CS: begin
                        next_need = 5'h01; // RL11
                        next_state = dli_pkg::S_DATA;
                    end
                    `DLI_OP_REPEAT: begin
                        next_need = bytesB(li[1:0]); // RL20
                        next_state = dli_pkg::S_OPND;
                    end
                    default: begin
                        if (li[`DLI_INFO_BIT]) begin
                            next_sendBuf = infoBlock;
                            next_sendLeft = li[0] ? `DLI_INFO_LONG : `DLI_KEY_BYTES;
                            next_state = dli_pkg::S_GUARD; // RL22
                        end else begin
                            next_need = `DLI_KEY_BYTES; // RL21
                            next_state = dli_pkg::S_DATA;
                        end
                    end
                endcase
            end
        end
        if (rxValid) begin
            next_guardDue = 1'b1;
        end
        // Link errors freeze the engine; a break is the only way out.
        if (rxError && state != dli_pkg::S_ERR) begin
            errSet = 1'b1;
            errCode = `DLI_ERR_LINK;
            next_state = dli_pkg::S_ERR; // RL24
            next_txValid = 1'b0;
            next_busReq = 1'b0;
        end
        if (rxBreak) begin
            next_state = dli_pkg::S_IDLE; // RL16
            next_rpt = 8'h00;
            next_guardCnt = 8'h00;
            next_txValid = 1'b0;
            next_busReq = 1'b0;
            next_guardDue = 1'b0;
        end
    end

    // Registers only.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state <= dli_pkg::S_IDLE; instr <= 8'h00; rpt <= 8'h00; ptr <= 32'h0;
            acc <= 64'h0; cnt <= 5'h00; need <= 5'h01; sendBuf <= 128'h0; sendLeft <= 5'h00;
            guardDue <= 1'b0; guardCnt <= 8'h00; dataPhase <= 1'b1; txValid <= 1'b0;
            txData <= 8'h00; busReq <= 1'b0; busCmd <= '0; keyStrobe <= 1'b0; keyData <= 64'h0;
        end else begin
            state <= next_state; instr <= next_instr; rpt <= next_rpt; ptr <= next_ptr;
            acc <= next_acc; cnt <= next_cnt; need <= next_need; sendBuf <= next_sendBuf;
            sendLeft <= next_sendLeft; guardDue <= next_guardDue; guardCnt <= next_guardCnt;
            dataPhase <= next_dataPhase; txValid <= next_txValid; txData <= next_txData;
            busReq <= next_busReq; busCmd <= next_busCmd; keyStrobe <= next_keyStrobe;
            keyData <= next_keyData;
        end
    end

    // ==================================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_storeDone;
        state == dli_pkg::S_BUS && busAck && !busErr && busCmd.we && !rxBreak && !rxError;
    endsequence
    sequence s_txQuiet;
        !txValid [*2];
    endsequence

    property p_ackAfterStore;
        s_storeDone |=> sendBuf[7:0] == `DLI_ACK_BYTE && sendLeft == 5'h01 && state == dli_pkg::S_GUARD;
    endproperty
    a_ackAfterStore: assert property (p_ackAfterStore) else $error("no acknowledge queued after store"); // RL5

    property p_postInc;
        state == dli_pkg::S_BUS && busAck && !busErr && opc[0] && pm == `DLI_PTR_INC
            |=> ptr == $past(ptr) + 32'(bytesB($past(instr[1:0])));
    endproperty
    a_postInc: assert property (p_postInc) else $error("pointer not advanced by data width"); // RL4

    property p_ptrHeld;
        state == dli_pkg::S_BUS && opc[0] && pm == `DLI_PTR_AT |=> $stable(ptr);
    endproperty
    a_ptrHeld: assert property (p_ptrHeld) else $error("pointer moved in plain mode"); // RL4

    property p_guardWait;
        state == dli_pkg::S_GUARD && guardDue && guardCnt < guardLimit && !rxBreak |=> !txValid;
    endproperty
    a_guardWait: assert property (p_guardWait) else $error("byte sent before guard bits elapsed"); // RL2

    property p_repeatDec;
        finish && rpt != 8'h00 && !rxBreak && !rxError |=> rpt == $past(rpt) - 8'h01 && state != dli_pkg::S_IDLE;
    endproperty
    a_repeatDec: assert property (p_repeatDec) else $error("repeat iteration not started"); // RL13

    property p_breakIdle;
        rxBreak |=> state == dli_pkg::S_IDLE && rpt == 8'h00 && !txValid && !busReq;
    endproperty
    a_breakIdle: assert property (p_breakIdle) else $error("break did not reset engine"); // RL16

    property p_errHold;
        state == dli_pkg::S_ERR && !rxBreak |=> state == dli_pkg::S_ERR && !txValid && !busReq;
    endproperty
    a_errHold: assert property (p_errHold) else $error("error state left without break"); // RL24

    property p_csWriteSilent;
        csWe && state == dli_pkg::S_DATA && rpt == 8'h00 && !rxError |=> s_txQuiet;
    endproperty
    a_csWriteSilent: assert property (p_csWriteSilent) else $error("control write produced a reply"); // RL10

    property p_keySilent;
        keyStrobe |-> !txValid && state != dli_pkg::S_SEND;
    endproperty
    a_keySilent: assert property (p_keySilent) else $error("key produced a reply"); // RL22

endmodule : dli_link_engine

`default_nettype wire

// ==== include/dli_pkg.sv ====
// Types shared by the debug link instruction engine.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package dli_pkg;

    // Engine states, one-hot.
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_OPND = 7'b0000010,
        S_DATA = 7'b0000100,
        S_BUS = 7'b0001000,
        S_GUARD = 7'b0010000,
        S_SEND = 7'b0100000,
        S_ERR = 7'b1000000
    } dli_state_t;

    // One data-space bus request.
    typedef struct packed {
        logic we;
        logic wide;
        logic [31:0] addr;
        logic [15:0] wdata;
    } dli_bus_cmd_t;

endpackage : dli_pkg

`default_nettype wire

// ==== include/dli_regs.svh ====
// Constants of the debug link instruction engine: opcodes, field positions,
// encodings, control/status addresses and reset values.
// Assumes it is included once per compilation unit by its bare name.
`ifndef DLI_REGS_SVH
`define DLI_REGS_SVH

// ==================================================================
// Instruction byte fields
`define DLI_OPC_MSB 7
`define DLI_OPC_LSB 5
`define DLI_MODE_MSB 3
`define DLI_MODE_LSB 2
`define DLI_INFO_BIT 2

// ==================================================================
// Opcodes
`define DLI_OP_LOAD_DIRECT 3'h0
`define DLI_OP_LOAD_PTR 3'h1
`define DLI_OP_WRITE_DIRECT 3'h2
`define DLI_OP_WRITE_PTR 3'h3
`define DLI_OP_READ_CS 3'h4
`define DLI_OP_REPEAT 3'h5
`define DLI_OP_WRITE_CS 3'h6
`define DLI_OP_KEY 3'h7

// ==================================================================
// Pointer modes, size codes and fixed bytes
`define DLI_PTR_AT 2'h0
`define DLI_PTR_INC 2'h1
`define DLI_PTR_REG 2'h2
`define DLI_SIZE_RSVD 2'h3
`define DLI_ACK_BYTE 8'h40
`define DLI_KEY_BYTES 5'h08
`define DLI_INFO_LONG 5'h10

// ==================================================================
// Control/status space
`define DLI_CS_STATUS 4'h1
`define DLI_CS_CTRL 4'h2
`define DLI_CS_RESET 8'h00
`define DLI_GUARD_BASE 8'h02
`define DLI_ERR_LINK 3'h1
`define DLI_ERR_CODE 3'h2
`define DLI_ERR_BUS 3'h3

`endif

// ==== test/debug_link_instruction_engine_tb.sv ====
// Bench for the link engine: host bytes in, replies queued and compared.
// Assumes the engine, its package and the bus partner are compiled first.
`timescale 1ns/10ps
`default_nettype none

module debug_link_instruction_engine_tb;
    // ==========
    // Signals
    logic core_clk, reset_n, rxValid, rxBreak, rxError, txValid, busReq, busAck, busErr, keyStrobe;
    logic bitTick = 1'b0;
    logic txReady = 1'b0;
    int keyCount = 0;
    logic [7:0] rxData, txData;
    logic [15:0] busRdata;
    logic [63:0] keyData, kexp;
    logic [127:0] info = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    logic [31:0] rs = 32'hA65F;
    logic [7:0] d [3];
    logic [7:0] exp [$];
    dli_pkg::dli_bus_cmd_t busCmd;
    int err_count = 0;
    int n_checks = 0;

    dli_link_engine dli_link_engine_i (.core_clk(core_clk), .reset_n(reset_n), .rxValid(rxValid), .rxData(rxData),
        .rxBreak(rxBreak), .rxError(rxError), .bitTick(bitTick), .txReady(txReady), .txValid(txValid),
        .txData(txData), .busReq(busReq), .busCmd(busCmd), .busAck(busAck), .busErr(busErr),
        .busRdata(busRdata), .keyStrobe(keyStrobe), .keyData(keyData), .infoBlock(info));
    dli_bus_partner dli_bus_partner_i (.core_clk(core_clk), .reset_n(reset_n), .busReq(busReq),
        .busCmd(busCmd), .busAck(busAck), .busErr(busErr), .busRdata(busRdata));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task automatic complete_run;
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    task automatic snd(input logic [7:0] b);
        @(posedge core_clk);
        rxValid <= 1'b1;
        rxData <= b;
        @(posedge core_clk);
        rxValid <= 1'b0;
    endtask : snd

    task automatic snd2(input logic [7:0] a, input logic [7:0] b);
        snd(a);
        snd(b);
    endtask : snd2

    // Bounded wait for the queue to drain; a stuck reply ends the run.
    task automatic wt;
        for (int i = 0; i < 3000 && exp.size() > 0; i++) @(posedge core_clk);
        if (exp.size() > 0) begin
            chk({56'h0, exp[0]}, {56'h0, ~exp[0]});
            complete_run();
        end
        repeat (2) @(posedge core_clk);
    endtask : wt

    task automatic xb(input logic [7:0] b);
        exp.push_back(b);
        wt();
    endtask : xb

    // Clock, random receiver stalls and sparse bit ticks.
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        rs <= lfsr(rs);
        txReady <= rs[2] | rs[5];
        bitTick <= ~bitTick & (rs[1:0] == 2'h0);
    end

    // An unexpected byte meets the inverse of itself and fails.
    always @(posedge core_clk) begin
        if (reset_n && txValid && txReady) begin
            chk({56'h0, exp.size() > 0 ? exp[0] : ~txData}, {56'h0, txData});
            if (exp.size() > 0) void'(exp.pop_front());
        end
        if (reset_n && keyStrobe) begin
            keyCount++;
            chk(kexp, keyData);
        end
    end

    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        {rxValid, rxBreak, rxError} = 3'h0;
        rxData = 8'h00;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        snd2(8'hC2, 8'h05);
        wt();
        snd(8'h82);
        xb(8'h05);
        snd2(8'h68, 8'h10);
        xb(8'h40);
        snd2(8'hA0, 8'h02);
        snd(8'h64);
        for (int k = 0; k < 3; k++) begin
            d[k] = rs[15:8];
            snd(d[k]);
            xb(8'h40);
        end
        snd2(8'h68, 8'h10);
        xb(8'h40);
        snd2(8'hA0, 8'h02);
        snd(8'h24);
        for (int k = 0; k < 3; k++) exp.push_back(d[k]);
        wt();
        snd(8'h28);
        xb(8'h13);
        snd2(8'h60, 8'h5A);
        xb(8'h40);
        snd(8'h20);
        xb(8'h5A);
        snd(8'h28);
        xb(8'h13);
        snd(8'hE0);
        for (int k = 0; k < 8; k++) begin
            kexp[8*k +: 8] = rs[7:0];
            snd(kexp[8*k +: 8]);
        end
        wt();
        chk(kexp, keyData);
        chk(64'h1, 64'(keyCount));
        snd(8'hE4);
        for (int k = 0; k < 8; k++) exp.push_back(info[8*k +: 8]);
        wt();
        // Direct store then direct load, each repeated once with the address resent.
        for (int j = 0; j < 2; j++) begin
            snd2(8'hA0, 8'h01);
            snd(j ? 8'h00 : 8'h40);
            for (int k = 0; k < 2; k++) begin
                snd(8'h20 + 8'(k));
                xb(j ? d[k] : 8'h40);
                if (j == 0) begin
                    snd(d[k]);
                    xb(8'h40);
                end
            end
        end
        @(posedge core_clk);
        rxError <= 1'b1;
        @(posedge core_clk);
        rxError <= 1'b0;
        snd(8'h82);
        repeat (60) @(posedge core_clk);
        rxBreak <= 1'b1;
        @(posedge core_clk);
        rxBreak <= 1'b0;
        snd(8'h81);
        xb(8'h01);
        complete_run();
    end
endmodule : debug_link_instruction_engine_tb

`default_nettype wire

// ==== test/dli_bus_partner.sv ====
// Data-space bus slave model for the link engine.
// Assumes one clock; byte storage by the low address byte.
`timescale 1ns/10ps
`default_nettype none

module dli_bus_partner (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bus from the engine
    input wire logic busReq,
    input wire dli_pkg::dli_bus_cmd_t busCmd,
    output logic busAck,
    output logic busErr,
    output logic [15:0] busRdata
);
    // ==========
    // Storage
    logic [7:0] mem [256];
    logic [1:0] slow;
    logic [15:0] word;
    // Latency varies from one to four cycles so slow answers are exercised.
    always @(posedge core_clk) begin
        busAck <= 1'b0;
        if (!reset_n) begin
            slow <= 2'h0;
        end else if (busReq && !busAck) begin
            slow <= slow + 2'h1;
            if (slow == busCmd.addr[1:0]) begin
                busAck <= 1'b1;
                if (busCmd.we) begin
                    mem[busCmd.addr[7:0]] <= busCmd.wdata[7:0];
                end
            end
        end
    end
    // Outside an answer the read lines show the inverse, never stale data.
    assign word = {8'h00, mem[busCmd.addr[7:0]]};
    assign busRdata = busAck ? word : ~word;
    assign busErr = 1'b0;
endmodule : dli_bus_partner

`default_nettype wire
